// ---- memory_map_mirror_decode_test.sv ----
/*
  Self-checking testbench for the memory map mirror decoder.
  Assumes mmd_pkg, mmd_decode and mmd_master_model are compiled first.
*/
`timescale 1ns/1ps
module memory_map_mirror_decode_test;
  import mmd_pkg::*;

  // Clock, reset and side inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic swap = 1'b0;
  logic vec_req = 1'b0;
  logic vec_brk = 1'b0;
  logic [7:0] lo = 8'h00;
  logic [7:0] hi = 8'h00;
  // Master request lines
  logic req, wr, fetch;
  logic [19:0] addr;
  logic [7:0] wdata, bmask;
  // Decoder results
  mmd_tgt_t tgt;
  mmd_area_t area;
  logic [19:0] phys, vec_addr, entry;
  logic valid, deny, msel;
  logic [7:0] rdata;
  int failures = 0;
  int cmp_count = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Parts under test; sizes passed explicitly
  mmd_decode #(.FLASH_BYTES(131072), .RAM_BASE(20'hfe300)) i_dut (
    .clk_i(clk), .rst_i(rst), .req_i(req), .addr_i(addr), .wr_i(wr),
    .fetch_i(fetch), .wdata_i(wdata), .bmask_i(bmask), .swap_i(swap),
    .vec_req_i(vec_req), .vec_break_i(vec_brk), .lo_byte_i(lo), .hi_byte_i(hi),
    .tgt_o(tgt), .area_o(area), .phys_o(phys), .valid_o(valid), .deny_o(deny),
    .rdata_o(rdata), .vec_addr_o(vec_addr), .entry_o(entry), .mirror_sel_o(msel));
  mmd_master_model i_master (.clk_i(clk), .req_o(req), .addr_o(addr), .wr_o(wr),
    .fetch_o(fetch), .wdata_o(wdata), .bmask_o(bmask));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset held two cycles, released off the sampling edge by NBA
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Read access; phys 20'hfffff means phys is not compared
  task automatic dec(input logic [19:0] a, input logic f, input mmd_tgt_t t,
                     input logic dn, input logic [19:0] p, input mmd_area_t ar);
    i_master.access(a, 1'b0, f, 8'h00, 8'h00);
    check(20'(valid), 20'h1);
    check(20'(tgt), 20'(t));
    check(20'(deny), 20'(dn));
    check(20'(area), 20'(ar));
    if (p != 20'hfffff)
      check(phys, p);
  endtask

  // Control register write, then two cycles of settling
  task automatic wr_ctl(input logic [7:0] d, input logic [7:0] m);
    i_master.access(MBC_ADDR, 1'b1, 1'b0, d, m);
    check(20'(tgt), 20'(MMD_TGT_SFR));
    repeat (2) @(posedge clk);
  endtask

  task automatic rd_ctl(input logic [7:0] exp);
    i_master.access(MBC_ADDR, 1'b0, 1'b0, 8'h00, 8'h00);
    check(20'(rdata), 20'(exp));
    check(20'(msel), 20'(exp[0]));
  endtask

  // Vector slot latch and table word assembly
  task automatic vec(input logic b, input logic [7:0] l, input logic [7:0] h);
    @(posedge clk);
    vec_req <= 1'b1;
    vec_brk <= b;
    lo <= l;
    hi <= h;
    @(posedge clk);
    vec_req <= 1'b0;
    #1;
    check(vec_addr, b ? VEC_BREAK : VEC_RESET);
    check(entry, {4'h0, h, l});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung decoder
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // Test sequence
  initial begin
    do_reset();
    rd_ctl(8'h00);
    dec(20'h00000, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h00000, MMD_AREA_VEC);
    dec(20'h0007f, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h0007f, MMD_AREA_VEC);
    dec(20'h00080, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h00080, MMD_AREA_TABLE_CALL_INSTRUCTION);
    dec(20'h000bf, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000bf, MMD_AREA_TABLE_CALL_INSTRUCTION);
    dec(20'h000c0, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000c0, MMD_AREA_OPT);
    dec(20'h000c3, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000c3, MMD_AREA_OPT);
    dec(20'h000c4, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000c4, MMD_AREA_SECID);
    dec(20'h000cd, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000cd, MMD_AREA_SECID);
    dec(20'h000ce, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h000ce, MMD_AREA_CODE);
    dec(20'h010c0, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h010c0, MMD_AREA_CODE);
    // Side inputs change on a rising edge, like every other stimulus
    @(posedge clk);
    swap <= 1'b1;
    dec(20'h01080, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h01080, MMD_AREA_TABLE_CALL_INSTRUCTION);
    dec(20'h010c3, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h010c3, MMD_AREA_OPT);
    dec(20'h010cd, 1'b0, MMD_TGT_FLASH, 1'b0, 20'h010cd, MMD_AREA_SECID);
    @(posedge clk);
    swap <= 1'b0;
    dec(20'h20000, 1'b0, MMD_TGT_PROH, 1'b1, 20'hfffff, MMD_AREA_CODE);
    dec(20'hf2000, 1'b0, MMD_TGT_MIRR, 1'b0, 20'h02000, MMD_AREA_CODE);
    dec(20'hfe2ff, 1'b0, MMD_TGT_MIRR, 1'b0, 20'h0e2ff, MMD_AREA_CODE);
    dec(20'hf2000, 1'b1, MMD_TGT_PROH, 1'b1, 20'hfffff, MMD_AREA_CODE);
    dec(20'hf0400, 1'b0, MMD_TGT_XSFR, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hfe300, 1'b0, MMD_TGT_RAM, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hfe300, 1'b1, MMD_TGT_RAM, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hffedf, 1'b1, MMD_TGT_RAM, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hffee0, 1'b0, MMD_TGT_GPR, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hffeff, 1'b0, MMD_TGT_GPR, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hffee0, 1'b1, MMD_TGT_GPR, 1'b1, 20'hfffff, MMD_AREA_CODE);
    dec(20'hfff00, 1'b0, MMD_TGT_SFR, 1'b0, 20'hfffff, MMD_AREA_CODE);
    dec(20'hfffff, 1'b0, MMD_TGT_SFR, 1'b0, 20'hfffff, MMD_AREA_CODE);
    i_master.access(20'hf2000, 1'b1, 1'b0, 8'h5a, 8'hff);
    check(20'(tgt), 20'(MMD_TGT_PROH));
    check(20'(deny), 20'h1);
    wr_ctl(8'h01, 8'h01);
    rd_ctl(8'h01);
    dec(20'hf2000, 0, MMD_TGT_MIRR, 0, 20'h12000, MMD_AREA_CODE);
    vec(1'b0, 8'h34, 8'h12);
    vec(1'b1, 8'hfe, 8'hff);
    do_reset();
    rd_ctl(8'h00);
    wr_ctl(8'hff, 8'hff);
    rd_ctl(8'h01);
    give_verdict();
  end
endmodule

// ---- mmd_area.sv ----
/*
  Classifies a flash address into its fixed area at the bottom of
  memory, and the boot-swap copies of all but the vector area when boot swap is in use.
  Assumes a purely combinational caller on the same clock.
*/
`timescale 1ns/1ps
module mmd_area
  import mmd_pkg::*;
(
  // Address in
  input  wire logic [19:0] addr_i,
  input  wire logic        swap_i,
  // Class out
  output mmd_pkg::mmd_area_t area_o
);

  // Area range check, used for the primary and the swap copy
  function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Copies live one page up; only honoured with boot swap
  always_comb begin
    area_o = MMD_AREA_CODE;
    if (in_rng(addr_i, VEC_LO, VEC_HI))
      area_o = MMD_AREA_VEC;
    else if (in_rng(addr_i, TABLE_CALL_INSTRUCTION_LO, TABLE_CALL_INSTRUCTION_HI) ||
             (swap_i && in_rng(addr_i, TABLE_CALL_INSTRUCTION_LO + SWAP_OFFSET, TABLE_CALL_INSTRUCTION_HI + SWAP_OFFSET)))
      area_o = MMD_AREA_TABLE_CALL_INSTRUCTION;
    else if (in_rng(addr_i, OPT_LO, OPT_HI) ||
             (swap_i && in_rng(addr_i, OPT_LO + SWAP_OFFSET, OPT_HI + SWAP_OFFSET)))
      area_o = MMD_AREA_OPT;
    else if (in_rng(addr_i, SECID_LO, SECID_HI) ||
             (swap_i && in_rng(addr_i, SECID_LO + SWAP_OFFSET, SECID_HI + SWAP_OFFSET)))
      area_o = MMD_AREA_SECID;
  end

endmodule

// ---- mmd_decode.sv ----
/*
  Memory map decoder with read-only flash mirror, register bank and SFR
  window decode, vector and table-call entry assembly, and the mirror
  bank control register.
  Assumes the CPU core and DMA controller present one registered access
  per cycle on clk_i; results appear one cycle after the request.
*/
`timescale 1ns/1ps

module mmd_decode
  import mmd_pkg::*;
#(
  parameter int          FLASH_BYTES = 131072,
  parameter logic [19:0] RAM_BASE    = 20'hfe300
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Access request from a bus master
  input  wire logic        req_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        fetch_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  bmask_i,
  input  wire logic        swap_i,
  // Table entry assembly
  input  wire logic        vec_req_i,
  input  wire logic        vec_break_i,
  input  wire logic [7:0]  lo_byte_i,
  input  wire logic [7:0]  hi_byte_i,
  // Decode result
  output mmd_pkg::mmd_tgt_t  tgt_o,
  output mmd_pkg::mmd_area_t area_o,
  output logic [19:0]      phys_o,
  output logic             valid_o,
  output logic             deny_o,
  output logic [7:0]       rdata_o,
  output logic [19:0]      vec_addr_o,
  output logic [19:0]      entry_o,
  output logic             mirror_sel_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]  ctrl;
    mmd_tgt_t    tgt;
    mmd_area_t   area;
    logic [19:0] phys;
    logic        valid;
    logic        deny;
    logic [7:0]  rdata;
    logic [19:0] vaddr;
    logic [19:0] entry;
  } mmd_state_t;

  mmd_state_t r;
  mmd_state_t next_r;
  mmd_area_t  area_c;

  localparam logic [19:0] FLASH_END = 20'(FLASH_BYTES - 1);

  // Range check reused by the SFR, GPR, RAM and XSFR decode
  function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Fixed-area classifier
  mmd_area u_area (
    .addr_i (addr_i),
    .swap_i (swap_i),
    .area_o (area_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_r       = r;
    next_r.valid = 1'b0;
    next_r.deny  = 1'b0;
    if (req_i) begin
      next_r.valid = 1'b1;
      next_r.area  = MMD_AREA_CODE;
      next_r.phys  = addr_i;
      next_r.rdata = 8'h00;
      // Window resources win over the mirror
      if (in_rng(addr_i, SFR_LO, 20'hfffff)) begin
        next_r.tgt = MMD_TGT_SFR;
        if (addr_i == MBC_ADDR) begin
          if (wr_i)
            next_r.ctrl = {7'h00, (wdata_i[MBC_SEL_BIT] & bmask_i[MBC_SEL_BIT]) |
                          (r.ctrl[MBC_SEL_BIT] & ~bmask_i[MBC_SEL_BIT])};
          else
            next_r.rdata = {7'h00, r.ctrl[MBC_SEL_BIT]};
        end
        next_r.deny = fetch_i;
      end else if (in_rng(addr_i, GPR_LO, GPR_HI)) begin
        next_r.tgt  = MMD_TGT_GPR;
        next_r.deny = fetch_i;       // No code from register banks
      end else if (in_rng(addr_i, RAM_BASE, RAM_TOP)) begin
        next_r.tgt  = MMD_TGT_RAM;   // Data, stack and fetch allowed
      end else if (in_rng(addr_i, XSFR_LO, XSFR_HI)) begin
        next_r.tgt  = MMD_TGT_XSFR;
        next_r.deny = fetch_i;
      end else if (addr_i >= MIRROR_LO) begin
        // Mirror: read-only data; a hole past the bank is prohibited
        if (fetch_i || wr_i) begin
          next_r.tgt  = MMD_TGT_PROH;
          next_r.deny = 1'b1;
        end else begin
          next_r.tgt  = MMD_TGT_MIRR;
          next_r.phys = {3'b000, r.ctrl[MBC_SEL_BIT], addr_i[15:0]};
          if (next_r.phys > FLASH_END) begin
            next_r.tgt  = MMD_TGT_PROH;
            next_r.deny = 1'b1;
          end
        end
      end else if (addr_i <= FLASH_END) begin
        next_r.tgt  = MMD_TGT_FLASH;
        next_r.area = area_c;
      end else begin
        next_r.tgt  = MMD_TGT_PROH;
        next_r.deny = 1'b1;
      end
    end
    // Entry slot: resets at the base, break at the top slot
    if (vec_req_i)
      next_r.vaddr = vec_break_i ? VEC_BREAK : VEC_RESET;
    // Two-byte entry keeps the target under 64 K
    next_r.entry = {4'h0, hi_byte_i, lo_byte_i} & NEAR_HI;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register the whole state; control resets to its documented value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r       <= '0;
      r.ctrl  <= MBC_RESET;
      r.tgt   <= MMD_TGT_NONE;
      r.area  <= MMD_AREA_CODE;
      r.vaddr <= VEC_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops
  assign tgt_o        = r.tgt;
  assign area_o       = r.area;
  assign phys_o       = r.phys;
  assign valid_o      = r.valid;
  assign deny_o       = r.deny;
  assign rdata_o      = r.rdata;
  assign vec_addr_o   = r.vaddr;
  assign entry_o      = r.entry;
  assign mirror_sel_o = r.ctrl[MBC_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  mirror_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && !wr_i && !fetch_i && addr_i >= 20'hf0800 && addr_i < RAM_BASE
    |=> tgt_o != MMD_TGT_MIRR || phys_o[16] == $past(r.ctrl[0]))
    else $error("mirror bank wrong");
  mirror_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && fetch_i |=> tgt_o != MMD_TGT_MIRR)
    else $error("fetch served from mirror");
  xsfr_win_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && addr_i <= XSFR_HI && addr_i >= XSFR_LO |=> tgt_o == MMD_TGT_XSFR)
    else $error("extended sfr not decoded");
  ctrl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r.ctrl[7:1] == 7'h00)
    else $error("control upper bits set");
  ctrl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && wr_i && addr_i == MBC_ADDR && bmask_i[0]
    |=> mirror_sel_o == $past(wdata_i[0]))
    else $error("control write lost");
  gpr_win_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && addr_i >= GPR_LO && addr_i <= GPR_HI
    |=> tgt_o == MMD_TGT_GPR && deny_o == $past(fetch_i))
    else $error("register bank decode");
  sfr_win_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && addr_i >= SFR_LO |=> tgt_o == MMD_TGT_SFR)
    else $error("sfr not decoded");
  ram_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && addr_i >= RAM_BASE && addr_i < GPR_LO
    |=> tgt_o == MMD_TGT_RAM && !deny_o)
    else $error("ram access denied");
  vec_slot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_req_i |=> vec_addr_o == ($past(vec_break_i) ? 20'h0007e : 20'h00000))
    else $error("vector slot wrong");
  entry_asm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    // The edge that releases reset still clears the flops, so skip it
    !rst_i |=> entry_o == {4'h0, $past(hi_byte_i), $past(lo_byte_i)})
    else $error("entry byte order");
  vec_area_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i && addr_i <= VEC_HI |=> area_o == MMD_AREA_VEC)
    else $error("vector area not flagged");

endmodule

// ---- mmd_master_model.sv ----
/*
  Bus master model standing for the CPU core and DMA controller in
  front of the decoder: one-cycle access pulses on clk_i.
  Assumes the decoder answers one cycle after the edge taking req_o.
*/
`timescale 1ns/1ps
module mmd_master_model (
  // Clock
  input  wire logic        clk_i,
  // Access request
  output logic             req_o,
  output logic [19:0]      addr_o,
  output logic             wr_o,
  output logic             fetch_o,
  output logic [7:0]       wdata_o,
  output logic [7:0]       bmask_o
);
  // Idle bus at time zero
  initial begin
    req_o   = 1'b0;
    addr_o  = 20'h00000;
    wr_o    = 1'b0;
    fetch_o = 1'b0;
    wdata_o = 8'h00;
    bmask_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access; released address, data and mask lines carry inverted values and
  // req, wr and fetch drop to 0, so stale data never looks valid. Callers write the control register once after each reset.
  // Callers own stack placement and unassigned SFR holes.
  task automatic access(input logic [19:0] a, input logic w, input logic f,
                        input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_i);
    req_o   <= 1'b1;
    addr_o  <= a;
    wr_o    <= w;
    fetch_o <= f;
    wdata_o <= d;
    bmask_o <= m;
    @(posedge clk_i);
    req_o   <= 1'b0;
    addr_o  <= ~a;
    wr_o    <= 1'b0;
    fetch_o <= 1'b0;
    wdata_o <= ~d;
    bmask_o <= ~m;
    #1;
  endtask
endmodule

// ---- mmd_pkg.sv ----
/*
  Package for the memory map mirror decoder: region bounds, register
  offset and layout, reset values and the target enumeration.
  Assumes a 20-bit byte address space and 8-bit data.
*/
package mmd_pkg;

  // Address and data widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // Fixed flash areas
  localparam logic [19:0] VEC_LO      = 20'h00000;
  localparam logic [19:0] VEC_HI      = 20'h0007f;
  localparam logic [19:0] VEC_RESET   = 20'h00000;
  localparam logic [19:0] VEC_BREAK   = 20'h0007e;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_LO    = 20'h00080;
  localparam logic [19:0] TABLE_CALL_INSTRUCTION_HI    = 20'h000bf;
  localparam logic [19:0] OPT_LO      = 20'h000c0;
  localparam logic [19:0] OPT_HI      = 20'h000c3;
  localparam logic [19:0] SECID_LO    = 20'h000c4;
  localparam logic [19:0] SECID_HI    = 20'h000cd;
  localparam logic [19:0] SWAP_OFFSET = 20'h01000;

  // Short-pointer range reachable by two-byte table entries
  localparam logic [19:0] NEAR_HI     = 20'h0ffff;

  // Mirror window and resources that take precedence in it
  localparam logic [19:0] MIRROR_LO   = 20'hf0000;
  localparam logic [19:0] XSFR_LO     = 20'hf0000;
  localparam logic [19:0] XSFR_HI     = 20'hf07ff;
  localparam logic [19:0] GPR_LO      = 20'hffee0;
  localparam logic [19:0] GPR_HI      = 20'hffeff;
  localparam logic [19:0] SFR_LO      = 20'hfff00;
  localparam logic [19:0] RAM_TOP     = 20'hffeff;

  // Mirror bank control register
  localparam logic [19:0] MBC_ADDR    = 20'hffffe;
  localparam logic [7:0]  MBC_RESET   = 8'h00;
  localparam int          MBC_SEL_BIT = 0;

  // Decode targets
  typedef enum logic [2:0] {
    MMD_TGT_NONE  = 3'b000,
    MMD_TGT_FLASH = 3'b001,
    MMD_TGT_MIRR  = 3'b010,
    MMD_TGT_RAM   = 3'b011,
    MMD_TGT_GPR   = 3'b100,
    MMD_TGT_SFR   = 3'b101,
    MMD_TGT_XSFR  = 3'b110,
    MMD_TGT_PROH  = 3'b111
  } mmd_tgt_t;

  // Fixed-area class of a flash address
  typedef enum logic [2:0] {
    MMD_AREA_CODE  = 3'b000,
    MMD_AREA_VEC   = 3'b001,
    MMD_AREA_TABLE_CALL_INSTRUCTION = 3'b010,
    MMD_AREA_OPT   = 3'b011,
    MMD_AREA_SECID = 3'b100
  } mmd_area_t;

endpackage
